// >>> dcsi_consts.svh
`ifndef DCSI_CONSTS_SVH
`define DCSI_CONSTS_SVH

`define DCSI_CLK_MHZ 100
`define DCSI_BAUD 115200
`define DCSI_BIT_CYCLES ((`DCSI_CLK_MHZ * 1000000) / `DCSI_BAUD)
`define DCSI_MAX_SUBSCRIBERS 16
`define DCSI_ADDR_MSB 7
`define DCSI_ADDR_LSB 4
`define DCSI_CMD_MSB 3
`define DCSI_CMD_LSB 0
`define DCSI_CMD_STATUS 4'h1
`define DCSI_CMD_TEACH 4'h2
`define DCSI_CMD_SERIAL 4'h3
`define DCSI_CMD_NAME 4'h4
`define DCSI_SERIAL_DEFAULT 8'h5a

`endif

// >>> dcsi_diag_host.sv
`timescale 1ns/1ns
`default_nettype none
module dcsi_diag_host #(
  parameter int BIT_CYCLES = 8
)
(
  input wire logic mclk,
  input wire logic rxLine,
  output logic txLine
);
  // Line marks high between frames
  initial txLine = 1'b1;

  // Command nibble then address nibble, LSB first; stop level selectable to inject faults
  task automatic sendFrame(input logic [3:0] a, input logic [3:0] c, input logic stp);
    logic [7:0] b;
    b = {a, c};
    @(negedge mclk);
    txLine = 1'b0;
    repeat (BIT_CYCLES) @(negedge mclk);
    for (int i = 0; i < 8; i++)
    begin
      txLine = b[i];
      repeat (BIT_CYCLES) @(negedge mclk);
    end
    txLine = stp;
    repeat (BIT_CYCLES) @(negedge mclk);
    txLine = 1'b1;
  endtask

  // Bounded wait, so a silent sensor reads as no reply
  task automatic recvByte(output logic got, output logic [7:0] b);
    int n;
    got = 1'b0;
    b = 8'h00;
    n = 0;
    while (rxLine !== 1'b0 && n < 200)
    begin
      @(negedge mclk);
      n++;
    end
    if (n < 200)
    begin
      repeat (BIT_CYCLES / 2) @(negedge mclk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT_CYCLES) @(negedge mclk);
        b[i] = rxLine;
      end
      repeat (BIT_CYCLES) @(negedge mclk);
      got = rxLine;
    end
  endtask
endmodule
`default_nettype wire

// >>> dcsi_diag_if.sv
`timescale 1ns/1ns
`default_nettype none
interface dcsi_diag_if;
  logic reqValid;
  logic [7:0] reqByte;
  logic rspValid;
  logic [7:0] rspByte;
  logic txBusy;
  logic txLine;

  modport core
  (
    input reqValid,
    input reqByte,
    input txBusy,
    input txLine,
    output rspValid,
    output rspByte
  );

  modport link
  (
    output reqValid,
    output reqByte,
    output txBusy,
    output txLine,
    input rspValid,
    input rspByte
  );
endinterface
`default_nettype wire

// >>> dcsi_diag_link.sv
`include "dcsi_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module dcsi_diag_link #(
  parameter int BIT_CYCLES = `DCSI_BIT_CYCLES
)
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic diagIn,
  dcsi_diag_if.link dl
);
  localparam int CW = $clog2(BIT_CYCLES);
  localparam logic [CW-1:0] BIT_LAST = CW'(BIT_CYCLES - 1);
  localparam logic [CW-1:0] HALF_BIT = CW'(BIT_CYCLES / 2);

  if (BIT_CYCLES < 4)
  begin : g_bad_rate
    $error("dcsi_diag_link: BIT_CYCLES must be at least 4");
  end

  dcsi_pkg::dcsi_rx_t rxState, next_rxState;
  logic [CW-1:0] rxCnt, next_rxCnt;
  logic [2:0] rxBit, next_rxBit;
  logic [7:0] rxShift, next_rxShift;
  logic reqValid, next_reqValid;
  logic [7:0] reqByte, next_reqByte;
  logic [CW-1:0] txCnt, next_txCnt;
  logic [3:0] txLeft, next_txLeft;
  logic [9:0] txShift, next_txShift;
  logic txLine, next_txLine;

  always_comb
  begin
    next_rxState = rxState;
    next_rxCnt = rxCnt;
    next_rxBit = rxBit;
    next_rxShift = rxShift;
    next_reqValid = 1'b0;
    next_reqByte = reqByte;
    case (rxState)
      dcsi_pkg::DCSI_RX_IDLE:
        if (!diagIn)
        begin
          next_rxState = dcsi_pkg::DCSI_RX_START;
          next_rxCnt = HALF_BIT;
        end
      dcsi_pkg::DCSI_RX_START:
        if (rxCnt != '0)
          next_rxCnt = rxCnt - 1'b1;
        else if (!diagIn)
        begin
          next_rxState = dcsi_pkg::DCSI_RX_DATA;
          next_rxCnt = BIT_LAST;
          next_rxBit = 3'h0;
        end
        else
          next_rxState = dcsi_pkg::DCSI_RX_IDLE;
      dcsi_pkg::DCSI_RX_DATA:
        if (rxCnt != '0)
          next_rxCnt = rxCnt - 1'b1;
        else
        begin
          next_rxShift = {diagIn, rxShift[7:1]};
          next_rxCnt = BIT_LAST;
          next_rxBit = rxBit + 3'h1;
          if (rxBit == 3'h7)
            next_rxState = dcsi_pkg::DCSI_RX_STOP;
        end
      dcsi_pkg::DCSI_RX_STOP:
        if (rxCnt != '0)
          next_rxCnt = rxCnt - 1'b1;
        else
        begin
          // Bad stop bit drops the frame silently
          next_rxState = dcsi_pkg::DCSI_RX_IDLE;
          next_reqValid = diagIn;
          if (diagIn)
            next_reqByte = rxShift;
        end
      default:
        next_rxState = dcsi_pkg::DCSI_RX_IDLE;
    endcase
  end

  always_comb
  begin
    next_txCnt = txCnt;
    next_txLeft = txLeft;
    next_txShift = txShift;
    next_txLine = txLine;
    if (txLeft == 4'h0)
    begin
      if (dl.rspValid)
      begin
        next_txShift = {1'b1, dl.rspByte, 1'b0};
        next_txLine = 1'b0;
        next_txLeft = 4'ha;
        next_txCnt = BIT_LAST;
      end
    end
    else if (txCnt != '0)
      next_txCnt = txCnt - 1'b1;
    else
    begin
      next_txLeft = txLeft - 4'h1;
      next_txCnt = BIT_LAST;
      next_txShift = {1'b1, txShift[9:1]};
      next_txLine = (txLeft > 4'h1) ? txShift[1] : 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      rxState <= dcsi_pkg::DCSI_RX_IDLE;
      rxCnt <= '0;
      rxBit <= 3'h0;
      rxShift <= 8'h00;
      reqValid <= 1'b0;
      reqByte <= 8'h00;
      txCnt <= '0;
      txLeft <= 4'h0;
      txShift <= 10'h3ff;
      txLine <= 1'b1;
    end
    else
    begin
      rxState <= next_rxState;
      rxCnt <= next_rxCnt;
      rxBit <= next_rxBit;
      rxShift <= next_rxShift;
      reqValid <= next_reqValid;
      reqByte <= next_reqByte;
      txCnt <= next_txCnt;
      txLeft <= next_txLeft;
      txShift <= next_txShift;
      txLine <= next_txLine;
    end
  end

  assign dl.reqValid = reqValid;
  assign dl.reqByte = reqByte;
  assign dl.txBusy = (txLeft != 4'h0);
  assign dl.txLine = txLine;
endmodule
`default_nettype wire

// >>> dcsi_pkg.sv
package dcsi_pkg;
  typedef enum logic [1:0]
  {
    DCSI_NORMAL = 2'b00,
    DCSI_UNEQUAL = 2'b01,
    DCSI_LOCK = 2'b10
  } dcsi_plaus_t;

  typedef enum logic [1:0]
  {
    DCSI_RX_IDLE = 2'b00,
    DCSI_RX_START = 2'b01,
    DCSI_RX_DATA = 2'b10,
    DCSI_RX_STOP = 2'b11
  } dcsi_rx_t;
endpackage

// >>> dcsi_top.sv
`include "dcsi_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module dcsi_top #(
  parameter int BIT_CYCLES = `DCSI_BIT_CYCLES,
  parameter logic [7:0] SERIAL_NUMBER = `DCSI_SERIAL_DEFAULT // Arbitrary value
)
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic actuatorDetected,
  input wire logic unitReady,
  input wire logic safetyInCh1,
  input wire logic safetyInCh2,
  input wire logic diagIn,
  input wire logic [3:0] chainAddr,
  input wire logic [7:0] teachRemaining,
  input wire logic [7:0] actuatorName,
  output logic safetyOutCh1,
  output logic safetyOutCh2,
  output logic statusDiagOut,
  output logic inputFlash,
  output logic plausError,
  output logic linkActive
);
  if ($clog2(`DCSI_MAX_SUBSCRIBERS) != 4)
  begin : g_bad_chain
    $error("dcsi_top: chain address must be 4 bits wide");
  end

  dcsi_diag_if dl();

  dcsi_diag_link #(.BIT_CYCLES(BIT_CYCLES)) u_link
  (
    .mclk(mclk),
    .resetn(resetn),
    .diagIn(diagIn),
    .dl(dl.link)
  );

  dcsi_pkg::dcsi_plaus_t plaus, next_plaus;
  logic act, rdy, s1, s2, p1, p2;
  logic lowCh2, next_lowCh2;
  logic next_out1, next_out2, next_status, next_link, next_flash, next_error;
  logic rspValid, next_rspValid;
  logic [7:0] rspByte, next_rspByte;
  logic hit;

  // Plausibility tracking on sampled inputs
  always_comb
  begin
    next_plaus = plaus;
    next_lowCh2 = lowCh2;
    case (plaus)
      dcsi_pkg::DCSI_NORMAL:
        if (p1 && p2 && (s1 != s2))
        begin
          next_plaus = dcsi_pkg::DCSI_UNEQUAL;
          next_lowCh2 = !s2;
        end
      dcsi_pkg::DCSI_UNEQUAL:
        if (!s1 && !s2)
          next_plaus = dcsi_pkg::DCSI_NORMAL;
        else if ((s1 && s2) || (lowCh2 != !s2))
          next_plaus = dcsi_pkg::DCSI_LOCK;
      dcsi_pkg::DCSI_LOCK:
        if (!s1 && !s2)
          next_plaus = dcsi_pkg::DCSI_NORMAL;
      default:
        next_plaus = dcsi_pkg::DCSI_NORMAL;
    endcase
  end

  // Gate on the next state so entering lock never leaks a high cycle
  always_comb
  begin
    next_out1 = act && rdy && (next_plaus != dcsi_pkg::DCSI_LOCK) && s1;
    next_out2 = act && rdy && (next_plaus != dcsi_pkg::DCSI_LOCK) && s2;
    next_link = linkActive || dl.reqValid;
    next_status = linkActive ? dl.txLine : act;
    next_flash = (next_plaus != dcsi_pkg::DCSI_NORMAL);
    next_error = (next_plaus == dcsi_pkg::DCSI_LOCK);
  end

  // Requests carry chain address high nibble, command low nibble
  assign hit = dl.reqValid && !dl.txBusy && !rspValid &&
               (dl.reqByte[`DCSI_ADDR_MSB:`DCSI_ADDR_LSB] == chainAddr);

  always_comb
  begin
    next_rspValid = 1'b0;
    next_rspByte = rspByte;
    if (hit)
    begin
      next_rspValid = 1'b1;
      case (dl.reqByte[`DCSI_CMD_MSB:`DCSI_CMD_LSB])
        `DCSI_CMD_STATUS:
          next_rspByte = {plausError, inputFlash, safetyOutCh2, safetyOutCh1, s2, s1, act, rdy};
        `DCSI_CMD_TEACH:
          next_rspByte = teachRemaining;
        `DCSI_CMD_SERIAL:
          next_rspByte = SERIAL_NUMBER;
        `DCSI_CMD_NAME:
          next_rspByte = actuatorName;
        default:
          next_rspValid = 1'b0;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      plaus <= dcsi_pkg::DCSI_NORMAL;
      lowCh2 <= 1'b0;
      act <= 1'b0;
      rdy <= 1'b0;
      s1 <= 1'b0;
      s2 <= 1'b0;
      p1 <= 1'b0;
      p2 <= 1'b0;
      safetyOutCh1 <= 1'b0;
      safetyOutCh2 <= 1'b0;
      statusDiagOut <= 1'b0;
      inputFlash <= 1'b0;
      plausError <= 1'b0;
      linkActive <= 1'b0;
      rspValid <= 1'b0;
      rspByte <= 8'h00;
    end
    else
    begin
      plaus <= next_plaus;
      lowCh2 <= next_lowCh2;
      act <= actuatorDetected;
      rdy <= unitReady;
      s1 <= safetyInCh1;
      s2 <= safetyInCh2;
      p1 <= s1;
      p2 <= s2;
      safetyOutCh1 <= next_out1;
      safetyOutCh2 <= next_out2;
      statusDiagOut <= next_status;
      inputFlash <= next_flash;
      plausError <= next_error;
      linkActive <= next_link;
      rspValid <= next_rspValid;
      rspByte <= next_rspByte;
    end
  end

  assign dl.rspValid = rspValid;
  assign dl.rspByte = rspByte;

  default clocking cb @(posedge mclk);
  endclocking
  // Checks sleep through reset; every output is forced low there anyway
  default disable iff (!resetn);

  sequence s_hit;
    hit && (dl.reqByte[3:0] == `DCSI_CMD_SERIAL);
  endsequence
  sequence s_reply;
    rspValid && (rspByte == SERIAL_NUMBER) ##1 dl.txBusy;
  endsequence

  a_off_no_actuator: assert property (!act |=> !safetyOutCh1 && !safetyOutCh2)
    else $error("safety output high with actuator absent");
  a_follow_ch1: assert property (act && rdy && next_plaus != dcsi_pkg::DCSI_LOCK
    |=> safetyOutCh1 == $past(s1))
    else $error("channel one output does not follow its input");
  a_follow_ch2: assert property (act && rdy && next_plaus != dcsi_pkg::DCSI_LOCK
    |=> safetyOutCh2 == $past(s2))
    else $error("channel two output does not follow its input");
  a_status_plain: assert property (!linkActive |=> statusDiagOut == $past(act))
    else $error("status output differs from actuator presence");
  a_status_diag: assert property (linkActive |=> statusDiagOut == $past(dl.txLine))
    else $error("status output not carrying link data");
  a_unequal_flag: assert property (plaus == dcsi_pkg::DCSI_NORMAL && p1 && p2 && s1 != s2
    |=> inputFlash && !plausError)
    else $error("unequal status not flagged");
  a_lock_entry: assert property (plaus == dcsi_pkg::DCSI_UNEQUAL && s1 && s2
    |=> plausError && !safetyOutCh1 && !safetyOutCh2)
    else $error("plausibility error not raised");
  a_lock_hold: assert property (plaus == dcsi_pkg::DCSI_LOCK && (s1 || s2)
    |=> !safetyOutCh1 && !safetyOutCh2 && plausError)
    else $error("output released during partial lock");
  a_lock_release: assert property (plaus == dcsi_pkg::DCSI_LOCK && !s1 && !s2
    |=> plaus == dcsi_pkg::DCSI_NORMAL)
    else $error("lock not released after both inputs low");
  a_link_enable: assert property (dl.reqValid |=> linkActive)
    else $error("link not enabled by request");
  a_serial_reply: assert property (s_hit |=> s_reply)
    else $error("serial number request not answered");
  a_reply_start: assert property (rspValid |=> !dl.txLine && dl.txBusy)
    else $error("reply start bit not sent");
  a_wrong_addr: assert property (dl.reqValid && (dl.reqByte[7:4] != chainAddr) |=> !rspValid)
    else $error("reply to a foreign address");
  a_tx_stop: assert property ($fell(dl.txBusy) |-> dl.txLine)
    else $error("link line not idle after reply");
endmodule
`default_nettype wire

// >>> dcsi_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
module dcsi_top_bench;
  localparam int BITC = 8;
  localparam logic [7:0] SERIAL = 8'hc3; // Arbitrary value
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic actuatorDetected = 1'b0;
  logic unitReady = 1'b0;
  logic safetyInCh1 = 1'b0;
  logic safetyInCh2 = 1'b0;
  logic diagIn;
  logic [3:0] chainAddr = 4'h5;
  logic [7:0] teachRemaining = 8'h00;
  logic [7:0] actuatorName = 8'h00;
  logic safetyOutCh1;
  logic safetyOutCh2;
  logic statusDiagOut;
  logic inputFlash;
  logic plausError;
  logic linkActive;
  logic [31:0] seed = 32'h00005de6;
  int nMismatch = 0;
  int numChecks = 0;
  // Walk steps: ch1 ch2 out1 out2 flash lock
  logic [5:0] walk [13] = '{6'h3c, 6'h16, 6'h33, 6'h23, 6'h00, 6'h3c, 6'h2a, 6'h00, 6'h3c, 6'h2a, 6'h13,
    6'h00, 6'h3c};
  logic [7:0] stat [3] = '{8'h3f, 8'h57, 8'h03};

  always #5 mclk = ~mclk;

  dcsi_top #(.BIT_CYCLES(BITC), .SERIAL_NUMBER(SERIAL)) i_dcsi_top (.mclk(mclk), .resetn(resetn),
    .actuatorDetected(actuatorDetected), .unitReady(unitReady), .safetyInCh1(safetyInCh1),
    .safetyInCh2(safetyInCh2), .diagIn(diagIn), .chainAddr(chainAddr), .teachRemaining(teachRemaining),
    .actuatorName(actuatorName), .safetyOutCh1(safetyOutCh1), .safetyOutCh2(safetyOutCh2),
    .statusDiagOut(statusDiagOut), .inputFlash(inputFlash), .plausError(plausError), .linkActive(linkActive));

  dcsi_diag_host #(.BIT_CYCLES(BITC)) i_dcsi_diag_host (.mclk(mclk), .rxLine(statusDiagOut), .txLine(diagIn));

  function automatic logic [31:0] nextRand(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  function automatic logic expOut(input logic a, input logic r, input logic c);
    return a & r & c;
  endfunction

  task automatic endOfTest();
    $display("checks %0d mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check1(input logic got, input logic exp, input string what);
    numChecks++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("[FAIL] %0t %s got %b want %b", $time, what, got, exp);
    end
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    numChecks++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Three edges cover the two-edge output latency
  task automatic drive(input logic a, input logic r, input logic c1, input logic c2);
    @(negedge mclk);
    actuatorDetected = a;
    unitReady = r;
    safetyInCh1 = c1;
    safetyInCh2 = c2;
    repeat (3) @(negedge mclk);
  endtask

  task automatic exch(input logic [3:0] a, input logic [3:0] c, input logic stp, input logic want,
    input logic [7:0] exp);
    logic got;
    logic [7:0] b;
    fork
      i_dcsi_diag_host.sendFrame(a, c, stp);
      i_dcsi_diag_host.recvByte(got, b);
    join
    check1(got, want, "reply");
    if (want)
      check8(b, exp, "byte");
  endtask

  initial
  begin
    repeat (20000) @(posedge mclk);
    nMismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    endOfTest();
  end

  initial
  begin
    repeat (12) @(negedge mclk);
    resetn = 1'b1;
    check1(safetyOutCh1 | safetyOutCh2 | plausError | inputFlash | linkActive, 1'b0, "reset");
    check1(statusDiagOut, 1'b0, "reset status");
    for (int k = 0; k < 40; k++)
    begin
      seed = nextRand(seed);
      drive(seed[0], seed[1] | seed[4], seed[2], seed[2]);
      check1(safetyOutCh1, expOut(seed[0], seed[1] | seed[4], seed[2]), "out1");
      check1(safetyOutCh2, expOut(seed[0], seed[1] | seed[4], seed[2]), "out2");
      check1(statusDiagOut, seed[0], "presence");
    end
    $display("test random levels done");
    foreach (walk[i])
    begin
      drive(1'b1, 1'b1, walk[i][5], walk[i][4]);
      check1(safetyOutCh1, walk[i][3], "out1");
      check1(safetyOutCh2, walk[i][2], "out2");
      check1(safetyOutCh1 ^ safetyOutCh2, walk[i][3] ^ walk[i][2], "pair");
      check1(inputFlash, walk[i][1], "flash");
      check1(plausError, walk[i][0], "lock");
    end
    check1(safetyOutCh1 & safetyOutCh2, 1'b1, "resume");
    // Per-switch delay the evaluator must budget: two edges
    @(negedge mclk);
    safetyInCh1 = 1'b0;
    safetyInCh2 = 1'b0;
    @(negedge mclk);
    check1(safetyOutCh1 & safetyOutCh2, 1'b1, "off early");
    @(negedge mclk);
    check1(safetyOutCh1 | safetyOutCh2, 1'b0, "off late");
    drive(1'b1, 1'b1, 1'b1, 1'b1);
    $display("test plausibility done");
    exch(4'h5, 4'h1, 1'b0, 1'b0, 8'h00);
    check1(linkActive, 1'b0, "link off");
    exch(4'h6, 4'h1, 1'b1, 1'b0, 8'h00);
    check1(linkActive, 1'b1, "link on");
    for (int r = 0; r < 3; r++)
    begin
      seed = nextRand(seed);
      teachRemaining = seed[7:0];
      actuatorName = seed[15:8];
      chainAddr = (r == 2) ? 4'hf : seed[19:16];
      if (r == 1)
        drive(1'b1, 1'b1, 1'b1, 1'b0);
      if (r == 2)
        drive(1'b1, 1'b1, 1'b0, 1'b0);
      exch(chainAddr, 4'h1, 1'b1, 1'b1, stat[r]);
      exch(chainAddr, 4'h2, 1'b1, 1'b1, teachRemaining);
      exch(chainAddr, 4'h3, 1'b1, 1'b1, SERIAL);
      exch(chainAddr, 4'h4, 1'b1, 1'b1, actuatorName);
      exch(chainAddr, 4'h7, 1'b1, 1'b0, 8'h00);
      exch(chainAddr + 4'h1, 4'h3, 1'b1, 1'b0, 8'h00);
    end
    drive(1'b0, 1'b1, 1'b0, 1'b0);
    check1(statusDiagOut, 1'b1, "link idle");
    $display("test link done");
    resetn = 1'b0;
    repeat (2) @(negedge mclk);
    resetn = 1'b1;
    drive(1'b1, 1'b1, 1'b0, 1'b0);
    check1(linkActive, 1'b0, "link cleared");
    check1(statusDiagOut, 1'b1, "presence");
    exch(chainAddr, 4'h3, 1'b1, 1'b1, SERIAL);
    $display("test power cycle done");
    endOfTest();
  end
endmodule
`default_nettype wire
